/* slsh_chk.sv */
// checker for the serial link lock and sync handshake endpoint
`timescale 1ns/1ps
module slsh_chk #(
	parameter LOCK_WORDS = 4
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// transmit side
	input wire sync_request_a_i,
	input wire sync_request_b_i,
	input wire serial_o,
	input wire training_pattern_o,
	// receive side
	input wire lock_indicator_n_o,
	input wire [9:0] parallel_out_o,
	input wire recovered_clk_o,
	input wire out_en_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_reset;
		$rose(rst_n_i) |-> lock_indicator_n_o && !out_en_o;
	endproperty
	a_reset: assert property (p_reset) else $error("lock after reset");
	property p_train;
		(sync_request_a_i || sync_request_b_i)[*4] |-> training_pattern_o;
	endproperty
	a_train: assert property (p_train) else $error("no training");
	property p_stop;
		(!(sync_request_a_i || sync_request_b_i))[*4] |-> !training_pattern_o;
	endproperty
	a_stop: assert property (p_stop) else $error("training held");
	property p_pat;
		training_pattern_o && $past(training_pattern_o, 4) && $rose(serial_o)
			|-> serial_o[*6] ##1 !serial_o[*6];
	endproperty
	a_pat: assert property (p_pat) else $error("bad training word");
	property p_rclk;
		$rose(recovered_clk_o) |-> !lock_indicator_n_o && out_en_o;
	endproperty
	a_rclk: assert property (p_rclk) else $error("word while unlocked");
	property p_loss;
		$rose(lock_indicator_n_o) |-> !recovered_clk_o && !out_en_o;
	endproperty
	a_loss: assert property (p_loss) else $error("outputs not released");
	property p_hold;
		!out_en_o && !$past(out_en_o) |-> $stable(parallel_out_o);
	endproperty
	a_hold: assert property (p_hold) else $error("data while unlocked");
	property p_oe;
		out_en_o == !lock_indicator_n_o;
	endproperty
	a_oe: assert property (p_oe) else $error("enable mismatch");
endmodule // slsh_chk

bind slsh_top slsh_chk #(.LOCK_WORDS(LOCK_WORDS)) i_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .serial_o(serial_o),
	.sync_request_a_i(sync_request_a_i), .sync_request_b_i(sync_request_b_i),
	.training_pattern_o(training_pattern_o), .out_en_o(out_en_o),
	.lock_indicator_n_o(lock_indicator_n_o), .parallel_out_o(parallel_out_o),
	.recovered_clk_o(recovered_clk_o));

/* slsh_link.sv */
// far side model: the transmitter's line looped back, inverted on demand
`timescale 1ns/1ps
module slsh_link (
	// line in and fault control
	input wire tx_line_i,
	input wire corrupt_i,
	// line to the receiver
	output wire rx_line_o
);
	// inverting swaps start and stop levels, breaking the framing
	assign rx_line_o = corrupt_i ? ~tx_line_i : tx_line_i;
endmodule // slsh_link

/* slsh_regs.vh */
// constants shared by the serial link lock and sync handshake block
`ifndef SLSH_REGS_VH
`define SLSH_REGS_VH

// frame layout, msb sent first: start bit, ten data bits, stop bit
`define SLSH_FRAME_W 12
`define SLSH_DATA_W 10
`define SLSH_START_POS 11
`define SLSH_STOP_POS 0
`define SLSH_START_BIT 1'b1
`define SLSH_STOP_BIT 1'b0
// six ones then six zeros
`define SLSH_TRAIN_PAT 12'hfc0
// shift and capture counters
`define SLSH_TX_BITS 4'hc
`define SLSH_RX_LOAD 4'he
`define SLSH_RX_LAST 4'h1
`define SLSH_CNT_ZERO 4'h0
// consecutive invalid words that end lock
`define SLSH_LOSS_WORDS 3'h4
// default consecutive valid words before lock is reported
`define SLSH_LOCK_WORDS 4

`endif

/* slsh_top.v */
// serial link endpoint: transmitter, receiver lock detector and outputs
// How it works
// RULE1 - training patterns go out for as long as either sync request is high.
// RULE2 - the active-low lock indicator stays high from reset until lock.
// RULE3 - the system feeds the lock indicator back to a sync request input.
// RULE4 - while locked, each received word appears on the parallel outputs.
// RULE5 - lock is lost only after four invalid framing words in a row.
// RULE6 - up to three words before the loss may be output though invalid.
// RULE7 - the consumer treats the three words before a loss as suspect.
// RULE8 - after a loss training is resent and the receiver locks again.
// RULE9 - lock is reached on ordinary data as well as on training patterns.
// RULE10 - a training word is six ones followed by six zeros.
// RULE11 - training stops only after both sync requests are low again.
// RULE12 - each word is framed by a high start bit and a low stop bit.
// RULE13 - on lock loss the indicator goes high and outputs are released.
// RULE14 - a correctly framed word clears the invalid word counter.
// RULE15 - lock is reported after stable framing and held until a loss.
`timescale 1ns/1ps
`include "slsh_regs.vh"

module slsh_top #(
	parameter LOCK_WORDS = `SLSH_LOCK_WORDS
) (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// transmit pins
	input wire tclk_i,
	input wire [`SLSH_DATA_W-1:0] tx_data_i,
	input wire sync_request_a_i,
	input wire sync_request_b_i,
	output wire serial_o,
	output wire training_pattern_o,
	// receive pins
	input wire rclk_i,
	input wire serial_i,
	output wire lock_indicator_n_o,
	output wire [`SLSH_DATA_W-1:0] parallel_out_o,
	output wire recovered_clk_o,
	output wire out_en_o
);

	localparam ST_HUNT = 1'b0;
	localparam ST_LOCK = 1'b1;
	localparam [31:0] LOCK_W32 = LOCK_WORDS;
	// the lock target fits the four-bit good word counter
	localparam [3:0] LOCK_N = LOCK_W32[3:0];

	reg rclk_m_r;
	reg rclk_s_r;
	reg rclk_d_r;
	reg ser_m_r;
	reg ser_s_r;
	reg [3:0] cap_cnt_r;
	reg [`SLSH_FRAME_W-2:0] cap_r;
	reg state_r;
	reg state_nxt;
	reg [3:0] good_cnt_r;
	reg [3:0] good_cnt_nxt;
	reg [2:0] bad_cnt_r;
	reg [2:0] bad_cnt_nxt;
	reg [`SLSH_DATA_W-1:0] pout_r;
	reg rec_clk_r;
	reg lock_n_r;
	wire rclk_rise;
	wire word_done;
	wire [`SLSH_FRAME_W-1:0] word;
	wire word_ok;

	// transmitter
	slsh_tx u_tx (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tclk_i(tclk_i),
		.tx_data_i(tx_data_i),
		.sync_request_a_i(sync_request_a_i),
		.sync_request_b_i(sync_request_b_i),
		.serial_o(serial_o),
		.training_o(training_pattern_o)
	);

	// two-stage synchronisers for the receive pins
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			rclk_m_r <= 1'b0;
			rclk_s_r <= 1'b0;
			rclk_d_r <= 1'b0;
			ser_m_r <= 1'b0;
			ser_s_r <= 1'b0;
		end else begin
			rclk_m_r <= rclk_i;
			rclk_s_r <= rclk_m_r;
			rclk_d_r <= rclk_s_r;
			ser_m_r <= serial_i;
			ser_s_r <= ser_m_r;
		end
	end

	assign rclk_rise = rclk_s_r & ~rclk_d_r;

	// capture twelve bits per reference edge, after the pin latency
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			cap_cnt_r <= `SLSH_CNT_ZERO;
			cap_r <= {(`SLSH_FRAME_W-1){1'b0}};
		end else if (rclk_rise) begin
			cap_cnt_r <= `SLSH_RX_LOAD;
		end else if (cap_cnt_r != `SLSH_CNT_ZERO) begin
			cap_cnt_r <= cap_cnt_r - 4'h1;
			if (cap_cnt_r <= `SLSH_TX_BITS)
				cap_r <= {cap_r[`SLSH_FRAME_W-3:0], ser_s_r};
		end
	end

	assign word_done = ~rclk_rise && (cap_cnt_r == `SLSH_RX_LAST);
	assign word = {cap_r, ser_s_r};
	// embedded clock check on start and stop bits
	assign word_ok = (word[`SLSH_START_POS] == `SLSH_START_BIT) &&
		(word[`SLSH_STOP_POS] == `SLSH_STOP_BIT); // [RULE12]

	// lock detector next state
	always @* begin
		state_nxt = state_r;
		good_cnt_nxt = good_cnt_r;
		bad_cnt_nxt = bad_cnt_r;
		if (word_done) begin
			case (state_r)
			ST_HUNT: begin
				// any framed traffic counts, data or training
				if (word_ok) begin // [RULE9]
					if (good_cnt_r + 4'h1 >= LOCK_N) begin
						state_nxt = ST_LOCK; // [RULE15] [RULE8]
						good_cnt_nxt = 4'h0;
					end else begin
						good_cnt_nxt = good_cnt_r + 4'h1;
					end
				end else begin
					good_cnt_nxt = 4'h0;
				end
				bad_cnt_nxt = 3'h0;
			end
			default: begin
				if (word_ok) begin
					bad_cnt_nxt = 3'h0; // [RULE14]
				end else if (bad_cnt_r + 3'h1 == `SLSH_LOSS_WORDS) begin
					state_nxt = ST_HUNT; // [RULE5]
					bad_cnt_nxt = 3'h0;
				end else begin
					bad_cnt_nxt = bad_cnt_r + 3'h1;
				end
			end
			endcase
		end
	end

	// lock state, indicator and output registers
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r <= ST_HUNT;
			good_cnt_r <= 4'h0;
			bad_cnt_r <= 3'h0;
			lock_n_r <= 1'b1; // [RULE2]
			pout_r <= {`SLSH_DATA_W{1'b0}};
			rec_clk_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			good_cnt_r <= good_cnt_nxt;
			bad_cnt_r <= bad_cnt_nxt;
			lock_n_r <= (state_nxt != ST_LOCK); // [RULE2] [RULE13]
			// suspect words before a loss still pass out
			if (word_done && state_r == ST_LOCK && state_nxt == ST_LOCK) begin
				pout_r <= word[`SLSH_FRAME_W-2:1]; // [RULE4] [RULE6]
				rec_clk_r <= 1'b1;
			end else if (rclk_rise || state_nxt != ST_LOCK) begin
				rec_clk_r <= 1'b0;
			end
		end
	end

	assign lock_indicator_n_o = lock_n_r;
	// outputs released whenever lock is absent
	assign out_en_o = ~lock_n_r; // [RULE13]
	assign parallel_out_o = pout_r;
	assign recovered_clk_o = rec_clk_r;

endmodule // slsh_top

/* slsh_tx.v */
// transmit side: frames parallel words or training patterns onto serial_o
`timescale 1ns/1ps
`include "slsh_regs.vh"

module slsh_tx (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// pins from the data source
	input wire tclk_i,
	input wire [`SLSH_DATA_W-1:0] tx_data_i,
	input wire sync_request_a_i,
	input wire sync_request_b_i,
	// link side
	output wire serial_o,
	output wire training_o
);

	reg tclk_m_r;
	reg tclk_s_r;
	reg tclk_d_r;
	reg sync_a_m_r;
	reg sync_a_s_r;
	reg sync_b_m_r;
	reg sync_b_s_r;
	reg [`SLSH_DATA_W-1:0] data_m_r;
	reg [`SLSH_DATA_W-1:0] data_s_r;
	reg [`SLSH_FRAME_W-1:0] shift_r;
	reg [3:0] bit_cnt_r;
	wire tclk_rise;
	wire train;

	// two-stage synchronisers for every pin
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			tclk_m_r <= 1'b0;
			tclk_s_r <= 1'b0;
			tclk_d_r <= 1'b0;
			sync_a_m_r <= 1'b0;
			sync_a_s_r <= 1'b0;
			sync_b_m_r <= 1'b0;
			sync_b_s_r <= 1'b0;
			data_m_r <= {`SLSH_DATA_W{1'b0}};
			data_s_r <= {`SLSH_DATA_W{1'b0}};
		end else begin
			tclk_m_r <= tclk_i;
			tclk_s_r <= tclk_m_r;
			tclk_d_r <= tclk_s_r;
			sync_a_m_r <= sync_request_a_i;
			sync_a_s_r <= sync_a_m_r;
			sync_b_m_r <= sync_request_b_i;
			sync_b_s_r <= sync_b_m_r;
			data_m_r <= tx_data_i;
			data_s_r <= data_m_r;
		end
	end

	assign tclk_rise = tclk_s_r & ~tclk_d_r;
	// training runs while either request is high, ends only when both low
	assign train = sync_a_s_r | sync_b_s_r; // [RULE1] [RULE11] [RULE8]
	assign training_o = train;

	// one frame per source clock rising edge, shifted out msb first
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			shift_r <= {`SLSH_FRAME_W{1'b0}};
			bit_cnt_r <= `SLSH_CNT_ZERO;
		end else if (tclk_rise) begin
			bit_cnt_r <= `SLSH_TX_BITS;
			if (train)
				shift_r <= `SLSH_TRAIN_PAT; // [RULE10]
			else
				shift_r <= {`SLSH_START_BIT, data_s_r,
					`SLSH_STOP_BIT}; // [RULE12]
		end else if (bit_cnt_r != `SLSH_CNT_ZERO) begin
			bit_cnt_r <= bit_cnt_r - 4'h1;
			shift_r <= {shift_r[`SLSH_FRAME_W-2:0], 1'b0};
		end
	end

	// line idles low once the frame has gone out
	assign serial_o = shift_r[`SLSH_FRAME_W-1];

endmodule // slsh_tx

/* test_slsh_top.sv */
// bench for the serial link lock and sync handshake endpoint
`timescale 1ns/1ps
module test_slsh_top;
	reg clock_i = 0, rst_n_i = 0, tclk = 0, sa = 0, sb = 0, bad = 0;
	reg [9:0] din = 10'h000;
	reg [19:0] rows [0:4];
	wire ser, train, lock_n, rck, oe, rx;
	wire [9:0] pout;
	integer fails = 0, cmp_count = 0, i, n = 0;
	// system clock and the word clock of the link
	always #4 clock_i = ~clock_i;
	always #62.5 tclk = ~tclk;
	slsh_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .tclk_i(tclk),
		.tx_data_i(din), .sync_request_a_i(sa), .sync_request_b_i(sb),
		.serial_o(ser), .training_pattern_o(train), .rclk_i(tclk),
		.serial_i(rx), .lock_indicator_n_o(lock_n), .parallel_out_o(pout),
		.recovered_clk_o(rck), .out_en_o(oe));
	slsh_link i_link (.tx_line_i(ser), .corrupt_i(bad), .rx_line_o(rx));
	// lock indicator fed back to the first sync request
	always @(negedge clock_i) sa <= lock_n;
	// count of words handed out
	always @(posedge rck) n = n + 1;
	task check(input [9:0] seen, input [9:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// move to the quiet gap between two frames
	task word_gap(input integer k);
		repeat (k) @(posedge tclk);
		repeat (2) @(negedge clock_i);
	endtask
	// k words with broken framing, then look at the outcome
	task burst(input integer k, input lk);
		bad = 1;
		@(negedge tclk) n = 0;
		word_gap(k);
		bad = 0;
		@(negedge tclk);
		check(10'(n), 10'h003);
		check(10'(lock_n), 10'(lk));
		check(10'(oe), 10'(!lk));
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		fails = fails + 1;
		tally_and_finish;
	end
	initial begin
		rows[0] = 20'hfffff;
		rows[1] = 20'h00000;
		rows[2] = 20'h55555;
		rows[3] = 20'haaaaa;
		rows[4] = 20'h80601;
		repeat (6) @(negedge clock_i);
		rst_n_i = 1;
		word_gap(1);
		check(10'(lock_n), 10'h001);
		check(10'(train), 10'h001);
		word_gap(10);
		check(10'(lock_n), 10'h000);
		check(10'(train), 10'h000);
		sb = 1;
		word_gap(3);
		check(10'(train), 10'h001);
		check(pout, 10'h3e0);
		sb = 0;
		word_gap(2);
		check(10'(train), 10'h000);
		// ordinary words through the link
		for (i = 0; i < 5; i = i + 1) begin
			din = rows[i][19:10];
			word_gap(3);
			check(pout, rows[i][9:0]);
		end
		word_gap(1);
		burst(3, 1'b0);
		word_gap(2);
		burst(4, 1'b1);
		word_gap(12);
		check(10'(lock_n), 10'h000);
		// reset in mid-run drops lock and clears the outputs
		rst_n_i = 0;
		repeat (6) @(negedge clock_i);
		check(10'(lock_n), 10'h001);
		check(10'(oe), 10'h000);
		check(pout, 10'h000);
		rst_n_i = 1;
		word_gap(12);
		check(10'(lock_n), 10'h000);
		tally_and_finish;
	end
endmodule // test_slsh_top
